// ==== dv/dspmac_fabric_model.sv ====
`default_nettype none
// Fabric-side overflow latch: the block reports overflow per update only, so a sticky copy lives out here.
module dspmac_fabric_model (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_clear_sticky,
    input wire logic [1:0] i_overflow,
    output logic [1:0] o_sticky
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_sticky <= 2'h0;
        end else if (i_clear_sticky) begin
            o_sticky <= 2'h0;
        end else begin
            o_sticky <= o_sticky | i_overflow;
        end
    end
endmodule // dspmac_fabric_model
`default_nettype wire

// ==== dv/tb_dsp_multiply_add_accumulate_modes.sv ====
`default_nettype none
module tb_dsp_multiply_add_accumulate_modes;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr;
    logic [71:0] opa = 72'h0, opb = 72'h0, resl, resr;
    logic [17:0] sha = 18'h0, shb = 18'h0, shoa, shob;
    logic [3:0] clr = 4'h0, ena = 4'hf;
    logic sga = 1'b0, sgb = 1'b0;
    logic [1:0] addsub = 2'h3, load = 2'h0, ovf, sticky;
    logic [143:0] res;
    int fail_count = 0;
    int n_compared = 0;
    int cycles = 0;
    dspmac_top dut (.i_clock(clock), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_operand_a(opa), .i_operand_b(opb), .i_shift_in_a(sha), .i_shift_in_b(shb), .o_shift_out_a(shoa),
        .o_shift_out_b(shob), .i_clear(clr), .i_ena(ena), .i_sign_a(sga), .i_sign_b(sgb), .i_add_sub(addsub),
        .i_acc_load(load), .o_result(res), .o_result_left(resl), .o_result_right(resr), .o_overflow(ovf));
    dspmac_fabric_model fabric (.i_clock(clock), .i_rst_n(rst_n), .i_clear_sticky(1'b0), .i_overflow(ovf),
        .o_sticky(sticky));
    always #12.5 clock = ~clock;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // The whole run needs well under a thousand cycles; this ceiling only catches a hang.
    always @(posedge clock) begin
        cycles++;
        if (cycles == 4000) begin
            fail_count++;
            print_verdict();
        end
    end
    task automatic check(input logic [143:0] seen, input logic [143:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd,
        output logic err);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            fail_count++;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Mode changes need run cleared first, since the block freezes its setup while running.
    task automatic setcfg(input logic [1:0] mode, input logic [1:0] size, input logic [1:0] shift);
        logic [31:0] w, rd;
        logic e;
        w = 32'h0;
        w[dspmac_pkg::CFG_MODE+:2] = mode;
        w[dspmac_pkg::CFG_SIZE+:2] = size;
        w[dspmac_pkg::CFG_SHIFT_A+:2] = shift;
        w[dspmac_pkg::CFG_RUN] = 1'b1;
        apb(1'b1, dspmac_pkg::ADDR_CONFIG, 32'h0, rd, e);
        apb(1'b1, dspmac_pkg::ADDR_CONFIG, w, rd, e);
    endtask
    function automatic logic [37:0] mul(input logic [17:0] a, input logic [17:0] b);
        return 38'($signed({sga & a[17], a}) * $signed({sgb & b[17], b}));
    endfunction
    task automatic drive(input logic [71:0] a, input logic [71:0] b);
        @(posedge clock);
        opa <= a;
        opb <= b;
        repeat (2) @(posedge clock);
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        logic [31:0] rd;
        logic e;
        apb(1'b0, dspmac_pkg::ADDR_CONFIG, 32'h0, rd, e);
        check(144'(rd), 144'(dspmac_pkg::CONFIG_RESET));
        apb(1'b1, dspmac_pkg::ADDR_STATUS, 32'hffff_ffff, rd, e);
        apb(1'b0, dspmac_pkg::ADDR_STATUS, 32'h0, rd, e);
        check(144'(rd), 144'h0);
        apb(1'b0, 12'h008, 32'h0, rd, e);
        check(144'({e, rd}), 144'h1_0000_0000);
    endtask
    task automatic t_simple;
        logic [71:0] a, b, l, r;
        logic [37:0] p;
        logic [143:0] e;
        a = {18'h3ffff, 18'h20001, 18'h1ffff, 18'h00003};
        b = {18'h3ffff, 18'h00005, 18'h3fffe, 18'h20000};
        setcfg(dspmac_pkg::MODE_SIMPLE, dspmac_pkg::SIZE_18, 2'h0);
        load <= 2'h3;
        for (int s = 0; s < 4; s++) begin
            sga <= s[0];
            sgb <= s[1];
            drive(a ^ 72'(s), b);
            for (int m = 0; m < 4; m++) begin
                p = mul(a[18*m+:18] ^ 18'(m == 0 ? s : 0), b[18*m+:18]);
                e[36*m+:36] = p[35:0];
            end
            check(res, e);
        end
        for (int u = 0; u < 8; u++) begin
            l[9*u+:9] = e[18*u+:9];
            r[9*u+:9] = e[18*u+9+:9];
        end
        check(144'({resl, resr}), 144'({l, r}));
        check(144'(ovf), 144'h0);
        load <= 2'h0;
    endtask
    task automatic t_wide;
        logic [35:0] a, b;
        a = 36'hf_ffff_fffd;
        b = 36'h8_0000_0003;
        sga <= 1'b0;
        sgb <= 1'b0;
        sha <= 18'h2aaaa;
        shb <= 18'h15555;
        setcfg(dspmac_pkg::MODE_SIMPLE, dspmac_pkg::SIZE_36, 2'h3);
        drive({36'h0, a}, {36'h0, b});
        check(144'(res[71:0]), 144'(72'(a) * 72'(b)));
    endtask
    task automatic t_mac;
        logic [37:0] p1, p3;
        setcfg(dspmac_pkg::MODE_MAC, dspmac_pkg::SIZE_18, 2'h0);
        load <= 2'h3;
        drive({18'h3ffff, 18'h2aaaa, 18'h3fff0, 18'h3ffff}, {18'h3ffff, 18'h15555, 18'h00101, 18'h3ffff});
        p1 = mul(18'h3fff0, 18'h00101);
        p3 = mul(18'h3ffff, 18'h3ffff);
        check(144'({res[125:72], res[53:0]}), 144'({54'(p3), 54'(p1)}));
        @(posedge clock);
        load <= 2'h0;
        repeat (2) @(posedge clock);
        #1;
        check(144'({res[125:72], res[53:0]}), 144'({54'(3 * p3), 54'(3 * p1)}));
        @(posedge clock);
        addsub <= 2'h0;
        repeat (5) @(posedge clock);
        #1;
        check(144'({ovf, res[51:0]}), 144'({2'h3, 52'(-p1)}));
        @(posedge clock);
        load <= 2'h3;
        addsub <= 2'h3;
        @(posedge clock);
        #1;
        check(144'({sticky, ovf, res[51:0]}), 144'({2'h3, 2'h0, 52'(p1)}));
        @(posedge clock);
        clr <= 4'h4;
        @(posedge clock);
        clr <= 4'h0;
        #1;
        check(144'({ovf, res}), 144'h0);
        load <= 2'h0;
    endtask
    // Complex product: real part in the low slot by subtraction, imaginary part by addition.
    task automatic t_adders;
        logic [37:0] p0, p1, p2, p3;
        logic [71:0] a, b;
        logic [31:0] rd;
        logic e;
        a = {18'h3fffc, 18'h00003, 18'h3fffc, 18'h00003};
        b = {18'h00005, 18'h3fffa, 18'h3fffa, 18'h00005};
        sga <= 1'b1;
        sgb <= 1'b1;
        setcfg(dspmac_pkg::MODE_ADD2, dspmac_pkg::SIZE_18, 2'h0);
        addsub <= 2'h2;
        drive(a, b);
        p0 = mul(a[17:0], b[17:0]);
        p1 = mul(a[35:18], b[35:18]);
        p2 = mul(a[53:36], b[53:36]);
        p3 = mul(a[71:54], b[71:54]);
        check(res, {72'($signed(p2) + $signed(p3)), 72'($signed(p0) - $signed(p1))});
        setcfg(dspmac_pkg::MODE_ADD4, dspmac_pkg::SIZE_18, 2'h0);
        addsub <= 2'h1;
        drive(a, b);
        check(144'(res[71:0]), 144'(72'($signed(p0) + $signed(p1) + $signed(p2) - $signed(p3))));
        apb(1'b1, dspmac_pkg::ADDR_CONFIG, 32'h8000_0000, rd, e);
        apb(1'b0, dspmac_pkg::ADDR_CONFIG, 32'h0, rd, e);
        check(144'(rd), 144'h8000_0003);
        apb(1'b0, dspmac_pkg::ADDR_STATUS, 32'h0, rd, e);
        check(144'(rd), 144'(32'h1 << dspmac_pkg::STAT_RUN));
    endtask
    task automatic t_nine;
        logic [31:0] w, rd;
        logic e;
        w = 32'h0;
        w[dspmac_pkg::CFG_SIZE+:2] = dspmac_pkg::SIZE_9;
        w[dspmac_pkg::CFG_PIPE] = 1'b1;
        w[dspmac_pkg::CFG_DLY_ADD+:2] = 2'h2;
        w[dspmac_pkg::CFG_RUN] = 1'b1;
        sga <= 1'b0;
        sgb <= 1'b0;
        apb(1'b1, dspmac_pkg::ADDR_CONFIG, 32'h0, rd, e);
        apb(1'b1, dspmac_pkg::ADDR_CONFIG, w, rd, e);
        drive({54'h0, 18'h3fe03}, {54'h0, 18'h00405});
        @(posedge clock);
        #1;
        check(res, 144'({18'h003fe, 18'h0000f}));
    endtask
    task automatic t_shift;
        setcfg(dspmac_pkg::MODE_ADD4, dspmac_pkg::SIZE_18, 2'h3);
        for (int i = 1; i < 5; i++) begin
            @(posedge clock);
            sha <= 18'(i);
            shb <= 18'(i + 16);
        end
        @(posedge clock);
        #1;
        check(144'({shoa, shob}), 144'({18'h1, 18'h11}));
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        t_regs();
        t_simple();
        t_wide();
        t_mac();
        t_adders();
        t_nine();
        t_shift();
        print_verdict();
    end
endmodule // tb_dsp_multiply_add_accumulate_modes
`default_nettype wire

// ==== hw/dspmac_pkg.sv ====
`default_nettype none
package dspmac_pkg;
    localparam int OPW = 18;
    localparam int SUBS = 4;
    localparam int UNITS = 8;
    localparam int PRODW = 38;
    localparam int ACCW = 52;
    localparam int RESW = 144;
    localparam int CTLW = 6;
    localparam logic [11:0] ADDR_CONFIG = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
    localparam int CFG_MODE = 0;
    localparam int CFG_SIZE = 2;
    localparam int CFG_SHIFT_A = 4;
    localparam int CFG_SHIFT_B = 5;
    localparam int CFG_PIPE = 6;
    localparam int CFG_DLY_SIGN = 8;
    localparam int CFG_DLY_ADD = 10;
    localparam int CFG_DLY_LOAD = 12;
    localparam int CFG_RUN = 31;
    localparam int STAT_OVF = 0;
    localparam int STAT_RUN = 2;
    localparam logic [1:0] SIZE_18 = 2'h0;
    localparam logic [1:0] SIZE_9 = 2'h1;
    localparam logic [1:0] SIZE_36 = 2'h2;
    localparam int EN_IN = 0;
    localparam int EN_PIPE = 1;
    localparam int EN_OUT = 2;
    localparam int EN_CTL = 3;
    typedef enum logic [1:0] {MODE_SIMPLE, MODE_MAC, MODE_ADD2, MODE_ADD4} dspmac_mode_t;
    typedef struct packed {
        dspmac_mode_t mode;
        logic [1:0] size;
        logic shift_a;
        logic shift_b;
        logic pipe_en;
        logic [1:0] dly_sign;
        logic [1:0] dly_add;
        logic [1:0] dly_load;
        logic run;
        logic [SUBS-1:0][OPW-1:0] a_reg;
        logic [SUBS-1:0][OPW-1:0] b_reg;
        logic [SUBS-1:0][PRODW-1:0] prod;
        logic [1:0][CTLW-1:0] ctl_dly;
        logic [1:0][ACCW-1:0] acc;
        logic [1:0] ovf;
        logic [RESW-1:0] result;
    } dspmac_state_t;
endpackage
`default_nettype wire

// ==== hw/dspmac_top.sv ====
`default_nettype none
module dspmac_top (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic [71:0] i_operand_a,
    input wire logic [71:0] i_operand_b,
    input wire logic [17:0] i_shift_in_a,
    input wire logic [17:0] i_shift_in_b,
    output logic [17:0] o_shift_out_a,
    output logic [17:0] o_shift_out_b,
    input wire logic [3:0] i_clear,
    input wire logic [3:0] i_ena,
    input wire logic i_sign_a,
    input wire logic i_sign_b,
    input wire logic [1:0] i_add_sub,
    input wire logic [1:0] i_acc_load,
    output logic [143:0] o_result,
    output logic [71:0] o_result_left,
    output logic [71:0] o_result_right,
    output logic [1:0] o_overflow
);
    dspmac_pkg::dspmac_state_t st;
    dspmac_pkg::dspmac_state_t nx;
    logic [5:0] ctl_now;
    logic [5:0] ctl;
    logic [5:0] c_sign;
    logic [5:0] c_add;
    logic [5:0] c_load;
    logic sa;
    logic sb;
    logic sg;
    logic wide;
    logic nine;
    logic [17:0] opa;
    logic [17:0] opb;
    logic [3:0][37:0] prod_c;
    logic [3:0][37:0] pv;
    logic signed [39:0] s18 [2];
    logic signed [39:0] s9 [4];
    logic signed [40:0] t18;
    logic signed [40:0] t9lo;
    logic signed [40:0] t9hi;
    logic signed [71:0] r72;
    logic signed [52:0] term [2];
    logic signed [52:0] sum [2];
    logic [1:0] ovf_c;
    logic [143:0] res;
    logic access;
    logic cfg_hit;
    logic stat_hit;

    ////////////////////////////////////////////////////////////////
    function automatic logic signed [37:0] mul18(input logic [17:0] a, input logic [17:0] b,
                                                 input logic sga, input logic sgb);
        logic signed [18:0] ax;
        logic signed [18:0] bx;
        ax = {sga & a[17], a};
        bx = {sgb & b[17], b};
        return 38'(ax * bx);
    endfunction

    function automatic logic [18:0] mul9(input logic [8:0] a, input logic [8:0] b,
                                         input logic sga, input logic sgb);
        logic signed [18:0] ax;
        logic signed [18:0] bx;
        ax = 19'($signed({sga & a[8], a}));
        bx = 19'($signed({sgb & b[8], b}));
        return 19'(ax * bx);
    endfunction

    function automatic logic signed [39:0] addsub(input logic signed [37:0] x,
                                                  input logic signed [37:0] y, input logic add);
        logic signed [39:0] xe;
        logic signed [39:0] ye;
        xe = 40'(x);
        ye = 40'(y);
        return add ? xe + ye : xe - ye;
    endfunction

    // Selecting the tap rather than shifting by a count keeps each control one mux deep.
    function automatic logic [5:0] dsel(input logic [1:0] d, input logic [5:0] c0,
                                        input logic [5:0] c1, input logic [5:0] c2);
        return (d == 2'h0) ? c0 : ((d == 2'h1) ? c1 : c2);
    endfunction

    ////////////////////////////////////////////////////////////////
    always_comb begin
        nx = st;
        opa = '0;
        opb = '0;
        res = '0;
        access = i_psel && i_penable;
        cfg_hit = i_paddr == dspmac_pkg::ADDR_CONFIG;
        stat_hit = i_paddr == dspmac_pkg::ADDR_STATUS;
        ctl_now = {i_sign_a, i_sign_b, i_add_sub, i_acc_load};
        // Each control takes its own tap, since the three delay fields are set independently.
        c_sign = dsel(st.dly_sign, ctl_now, st.ctl_dly[0], st.ctl_dly[1]);
        c_add = dsel(st.dly_add, ctl_now, st.ctl_dly[0], st.ctl_dly[1]);
        c_load = dsel(st.dly_load, ctl_now, st.ctl_dly[0], st.ctl_dly[1]);
        ctl[5:4] = c_sign[5:4];
        ctl[3:2] = c_add[3:2];
        ctl[1:0] = c_load[1:0];
        sa = ctl[5];
        sb = ctl[4];
        sg = sa || sb;
        wide = (st.size == dspmac_pkg::SIZE_36) && (st.mode == dspmac_pkg::MODE_SIMPLE);
        nine = st.size == dspmac_pkg::SIZE_9;
        // In wide mode sub-block m multiplies the a half m[0] by the b half m[1].
        for (int m = 0; m < 4; m++) begin
            opa = wide ? st.a_reg[m % 2] : st.a_reg[m];
            opb = wide ? st.b_reg[m / 2] : st.b_reg[m];
            if (nine) begin
                prod_c[m] = {mul9(opa[17:9], opb[17:9], sa, sb), mul9(opa[8:0], opb[8:0], sa, sb)};
            end else begin
                prod_c[m] = mul18(opa, opb, sa && (!wide || (m % 2 == 1)),
                                  sb && (!wide || (m / 2 == 1)));
            end
            pv[m] = st.pipe_en ? st.prod[m] : prod_c[m];
        end
        r72 = 72'($signed(pv[0])) + (72'($signed(pv[1])) <<< 18)
            + (72'($signed(pv[2])) <<< 18) + (72'($signed(pv[3])) <<< 36);
        // High add/sub control adds, low subtracts; one control per adder pair.
        s18[0] = addsub(pv[0], pv[1], ctl[2]);
        s18[1] = addsub(pv[2], pv[3], ctl[3]);
        s9[0] = addsub(38'($signed(pv[0][18:0])), 38'($signed(pv[1][18:0])), ctl[2]);
        s9[1] = addsub(38'($signed(pv[0][37:19])), 38'($signed(pv[1][37:19])), ctl[2]);
        s9[2] = addsub(38'($signed(pv[2][18:0])), 38'($signed(pv[3][18:0])), ctl[3]);
        s9[3] = addsub(38'($signed(pv[2][37:19])), 38'($signed(pv[3][37:19])), ctl[3]);
        t18 = 41'(s18[0]) + 41'(s18[1]);
        t9lo = 41'(s9[0]) + 41'(s9[2]);
        t9hi = 41'(s9[1]) + 41'(s9[3]);
        // Only sub-blocks two and four feed the accumulators.
        for (int j = 0; j < 2; j++) begin
            term[j] = nine ? 53'($signed(pv[2 * j + 1][18:0])) : 53'($signed(pv[2 * j + 1]));
            if (!ctl[2 + j]) begin
                term[j] = -term[j];
            end
            sum[j] = ctl[j] ? term[j] : {sg & st.acc[j][51], st.acc[j]} + term[j];
            ovf_c[j] = sg ? (sum[j][52] ^ sum[j][51]) : sum[j][52];
        end
        if (st.run && i_ena[dspmac_pkg::EN_CTL]) begin
            nx.ctl_dly[0] = ctl_now;
            nx.ctl_dly[1] = st.ctl_dly[0];
        end
        if (i_clear[dspmac_pkg::EN_CTL]) begin
            nx.ctl_dly = '0;
        end
        if (st.run && i_ena[dspmac_pkg::EN_IN]) begin
            for (int m = 0; m < 4; m++) begin
                if (st.shift_a && !wide) begin
                    nx.a_reg[m] = (m == 0) ? i_shift_in_a : st.a_reg[m - 1];
                end else begin
                    nx.a_reg[m] = i_operand_a[18 * m +: 18];
                end
                if (st.shift_b && !wide) begin
                    nx.b_reg[m] = (m == 0) ? i_shift_in_b : st.b_reg[m - 1];
                end else begin
                    nx.b_reg[m] = i_operand_b[18 * m +: 18];
                end
            end
        end
        if (i_clear[dspmac_pkg::EN_IN]) begin
            nx.a_reg = '0;
            nx.b_reg = '0;
        end
        if (st.run && i_ena[dspmac_pkg::EN_PIPE]) begin
            nx.prod = prod_c;
        end
        if (i_clear[dspmac_pkg::EN_PIPE]) begin
            nx.prod = '0;
        end
        if (st.mode == dspmac_pkg::MODE_MAC) begin
            if (st.run && i_ena[dspmac_pkg::EN_OUT]) begin
                for (int j = 0; j < 2; j++) begin
                    nx.acc[j] = sum[j][51:0];
                    nx.ovf[j] = ovf_c[j];
                end
            end
        end else begin
            nx.ovf = '0;
        end
        if (i_clear[dspmac_pkg::EN_OUT]) begin
            nx.acc = '0;
            nx.ovf = '0;
        end
        // The selected mode and the operand size (wide, nine) together decide what reaches the result buses.
        case (st.mode)
            dspmac_pkg::MODE_SIMPLE: begin
                if (wide) begin
                    res[71:0] = r72;
                end else begin
                    for (int m = 0; m < 4; m++) begin
                        res[36 * m +: 36] = nine ? {pv[m][36:19], pv[m][17:0]} : pv[m][35:0];
                    end
                end
            end
            dspmac_pkg::MODE_MAC: begin
                res[53:0] = {{2{sg & nx.acc[0][51]}}, nx.acc[0]};
                res[125:72] = {{2{sg & nx.acc[1][51]}}, nx.acc[1]};
            end
            dspmac_pkg::MODE_ADD2: begin
                if (nine) begin
                    for (int k = 0; k < 4; k++) begin
                        res[36 * k +: 36] = 36'(s9[k]);
                    end
                end else begin
                    res = {72'(s18[1]), 72'(s18[0])};
                end
            end
            dspmac_pkg::MODE_ADD4: begin
                res = nine ? {72'(t9hi), 72'(t9lo)} : {72'h0, 72'(t18)};
            end
            default: begin
                res = '0;
            end
        endcase
        if (st.run && i_ena[dspmac_pkg::EN_OUT]) begin
            nx.result = res;
        end
        if (i_clear[dspmac_pkg::EN_OUT]) begin
            nx.result = '0;
        end
        // Shape fields move only while stopped, so no product mixes two modes.
        if (access && i_pwrite && cfg_hit) begin
            if (!st.run) begin
                nx.mode = dspmac_pkg::dspmac_mode_t'(i_pwdata[dspmac_pkg::CFG_MODE +: 2]);
                nx.size = i_pwdata[dspmac_pkg::CFG_SIZE +: 2];
                nx.shift_a = i_pwdata[dspmac_pkg::CFG_SHIFT_A];
                nx.shift_b = i_pwdata[dspmac_pkg::CFG_SHIFT_B];
                nx.pipe_en = i_pwdata[dspmac_pkg::CFG_PIPE];
                nx.dly_sign = i_pwdata[dspmac_pkg::CFG_DLY_SIGN +: 2];
                nx.dly_add = i_pwdata[dspmac_pkg::CFG_DLY_ADD +: 2];
                nx.dly_load = i_pwdata[dspmac_pkg::CFG_DLY_LOAD +: 2];
            end
            nx.run = i_pwdata[dspmac_pkg::CFG_RUN];
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st <= '0;
        end else begin
            st <= nx;
        end
    end

    ////////////////////////////////////////////////////////////////
    always_comb begin
        o_prdata = '0;
        if (cfg_hit) begin
            o_prdata[dspmac_pkg::CFG_MODE +: 2] = st.mode;
            o_prdata[dspmac_pkg::CFG_SIZE +: 2] = st.size;
            o_prdata[dspmac_pkg::CFG_SHIFT_A] = st.shift_a;
            o_prdata[dspmac_pkg::CFG_SHIFT_B] = st.shift_b;
            o_prdata[dspmac_pkg::CFG_PIPE] = st.pipe_en;
            o_prdata[dspmac_pkg::CFG_DLY_SIGN +: 2] = st.dly_sign;
            o_prdata[dspmac_pkg::CFG_DLY_ADD +: 2] = st.dly_add;
            o_prdata[dspmac_pkg::CFG_DLY_LOAD +: 2] = st.dly_load;
            o_prdata[dspmac_pkg::CFG_RUN] = st.run;
        end else if (stat_hit) begin
            o_prdata[dspmac_pkg::STAT_OVF +: 2] = st.ovf;
            o_prdata[dspmac_pkg::STAT_RUN] = st.run;
        end
    end

    assign o_pready = 1'b1;
    assign o_pslverr = access && !cfg_hit && !stat_hit;
    assign o_result = st.result;
    assign o_overflow = st.ovf;
    assign o_shift_out_a = st.a_reg[3];
    assign o_shift_out_b = st.b_reg[3];

    for (genvar u = 0; u < dspmac_pkg::UNITS; u++) begin : g_unit
        assign o_result_left[9 * u +: 9] = st.result[18 * u +: 9];
        assign o_result_right[9 * u +: 9] = st.result[18 * u + 9 +: 9];
    end

    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    // A clear outranks the enable, so the update checks leave clear cycles out.
    AST_MODE_FROZEN: assert property (st.run && $past(st.run) |-> $stable(st.mode) && $stable(st.size))
        else $error("mode changed while running");

    AST_ACC_LOAD: assert property (st.mode == dspmac_pkg::MODE_MAC && st.run && i_ena[2] && !i_clear[2] && ctl[0]
        |=> st.acc[0] == $past(term[0][51:0]))
        else $error("load did not replace accumulator");

    AST_ACC_ADD: assert property (st.mode == dspmac_pkg::MODE_MAC && st.run && i_ena[2] && !i_clear[2] && !ctl[1]
        |=> st.acc[1] == 52'($past(st.acc[1]) + $past(term[1][51:0])))
        else $error("accumulator did not add");

    AST_ACC_SUB: assert property (st.mode == dspmac_pkg::MODE_MAC && st.run && i_ena[2] && !i_clear[2] && !ctl[0]
        && !ctl[2] && !nine |=> st.acc[0] == 52'($past(st.acc[0]) - 52'($signed($past(pv[1])))))
        else $error("accumulator did not subtract");

    AST_OVF_MODE: assert property (st.mode != dspmac_pkg::MODE_MAC |=> o_overflow == 2'h0)
        else $error("overflow outside accumulate mode");

    AST_OVF_LIVE: assert property (st.mode == dspmac_pkg::MODE_MAC && st.run && i_ena[2] && !i_clear[2]
        |=> o_overflow[0] == $past(ovf_c[0]))
        else $error("overflow not refreshed");

    AST_OUT_CLEAR: assert property (i_clear[2] |=> o_overflow == 2'h0 && o_result == '0)
        else $error("output clear ignored");

    AST_OUT_HOLD: assert property (!(st.run && i_ena[2]) && !i_clear[2] |=> $stable(o_result))
        else $error("result moved without enable");

    AST_SIMPLE_DIRECT: assert property (st.mode == dspmac_pkg::MODE_SIMPLE && !wide && !nine && st.run && i_ena[2]
        && !i_clear[2] |=> o_result[35:0] == $past(pv[0][35:0]))
        else $error("simple product not on output");

    AST_WIDE_PARALLEL: assert property (wide && st.run && i_ena[0] && !i_clear[0]
        |=> st.a_reg[0] == $past(i_operand_a[17:0]))
        else $error("wide mode used shift chain");

    AST_CHAIN: assert property (st.shift_b && !wide && st.run && i_ena[0] && !i_clear[0]
        |=> st.b_reg[2] == $past(st.b_reg[1]))
        else $error("chain did not shift");

    AST_DELAY2: assert property (st.dly_add == 2'h2 && $stable(st.dly_add) && st.run && $past(st.run)
        && i_ena[3] && $past(i_ena[3]) && !i_clear[3] && !$past(i_clear[3]) && !$past(i_clear[3], 2)
        |-> ##1 ctl[3:2] == $past(i_add_sub, 2))
        else $error("control delay wrong");

    AST_UNMAPPED: assert property (access && !cfg_hit && !stat_hit |-> o_pslverr && o_prdata == 32'h0)
        else $error("unmapped access not refused");

    COV_NINE_PIPE: cover property (nine && st.pipe_en && st.run && st.dly_add == 2'h2);
    COV_MAC_LOAD: cover property (st.mode == dspmac_pkg::MODE_MAC && st.run && i_ena[2] && ctl[0]);
    COV_WIDE: cover property (wide && st.run ##1 i_ena[2]);
    COV_ADD4: cover property (st.mode == dspmac_pkg::MODE_ADD4 && st.run && st.shift_a);
    COV_OVF: cover property (o_overflow[0]);
endmodule // dspmac_top
`default_nettype wire
